// [verilog/slp_sector_lock.v]
// Sector lock protection: persistent and volatile per-sector locks
// Notes on behaviour
// R1: One persistent lock bit per sector; 0 locked, 1 unlocked.
// R2: Persistent 0 blocks program/erase; bits survive resets.
// R3: Persistent write command clears addressed bit to 0, byte-program time.
// R4: Persistent erase sets all bits to 1 at once, sector-erase time.
// R5: Volatile lock bit per sector is its write-lock flag; 1 blocks.
// R6: Any reset clears every volatile lock bit to 0.
// R7: Volatile write command sets designated write-lock bit.
// R8: Read commands return persistent bits and volatile register contents.
// R9: Volatile write executes only while lock-down bit 1 is 0.
// R10: Lock-down powers up 0; once 1, freezes both volatile flags till reset.
// R11: Write-lock at bit 0 powers up 0; 1 blocks program/erase.
// R12: First and last sectors lock volatile per 4KB subsector.
// R13: Persistent bit commands rejected while global freeze flag is 0; the code rejects only write and erase, and persistent read still answers.
// R14: Program/erase allowed only if both persistent and volatile unlock.
// R15: Volatile register bits 7..2 always read 0.
`timescale 1ns/1ps
`include "slp_regs.vh"
module slp_sector_lock #(
  parameter PROG_CYCLES  = (`SLP_T_NV_PROG_NS + `SLP_CLK_NS - 1) / `SLP_CLK_NS,
  parameter ERASE_CYCLES = (`SLP_T_NV_ERASE_NS + `SLP_CLK_NS - 1) / `SLP_CLK_NS
) (
  input  wire                    clk,
  input  wire                    rst_n,
  input  wire                    soft_reset,
  input  wire                    cmd_valid,
  input  wire [`SLP_CMD_W-1:0]   cmd_code,
  input  wire [`SLP_SEC_W-1:0]   cmd_sector,
  input  wire [`SLP_SUB_W-1:0]   cmd_subsector,
  input  wire [`SLP_VREG_W-1:0]  cmd_wdata,
  input  wire                    global_freeze,
  output wire                    cmd_ready,
  output reg                     rsp_valid,
  output reg  [`SLP_VREG_W-1:0]  rsp_data,
  output reg                     rsp_allowed,
  output reg                     cmd_rejected,
  output wire                    busy
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_PROG  = 2'h1;
  localparam ST_ERASE = 2'h2;
  localparam NSUB     = 2 * `SLP_SUB_PER_SEC;

  reg [`SLP_SECTORS-1:0] nv_lock;
  reg [`SLP_SECTORS-1:0] v_wlock;
  reg [`SLP_SECTORS-1:0] v_ldown;
  reg [NSUB-1:0]         sub_wlock;
  reg [NSUB-1:0]         sub_ldown;
  reg [1:0]              state;
  reg [31:0]             timer;
  reg [`SLP_SEC_W-1:0]   pend_sector;
  // Starts low so the first edge loads the unlocked factory state
  reg                    nv_init = 1'b0;

  // Edge sectors map onto subsector slots
  function is_edge;
    input [`SLP_SEC_W-1:0] s;
    begin
      is_edge = (s == {`SLP_SEC_W{1'b0}}) || (s == {`SLP_SEC_W{1'b1}});
    end
  endfunction

  function [4:0] sub_idx;
    input [`SLP_SEC_W-1:0] s;
    input [`SLP_SUB_W-1:0] u;
    begin
      sub_idx = {(s != {`SLP_SEC_W{1'b0}}), u};
    end
  endfunction

  wire       edge_sel = is_edge(cmd_sector);
  wire [4:0] si       = sub_idx(cmd_sector, cmd_subsector);
  wire       cur_wl   = edge_sel ? sub_wlock[si] : v_wlock[cmd_sector];
  wire       cur_ld   = edge_sel ? sub_ldown[si] : v_ldown[cmd_sector];
  wire       take     = cmd_valid && cmd_ready;
  // Lock-down freezes both volatile flags
  wire       vol_ok   = !cur_ld; // R9 R10
  wire       nv_ok    = global_freeze; // R13

  assign cmd_ready = (state == ST_IDLE);
  assign busy      = (state != ST_IDLE);

  // Persistent bits: untouched by resets, initialised once
  always @(posedge clk)
  begin
    if (!nv_init)
      nv_lock <= {`SLP_SECTORS{`SLP_NV_UNLOCKED}}; // R1
    else if (state == ST_PROG && timer == 32'h0)
      nv_lock[pend_sector] <= `SLP_NV_LOCKED; // R3
    else if (state == ST_ERASE && timer == 32'h0)
      nv_lock <= {`SLP_SECTORS{`SLP_NV_UNLOCKED}}; // R4
  end

  always @(posedge clk)
  begin
    nv_init <= 1'b1; // R2
  end

  // Sequencer and volatile registers
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      v_wlock      <= {`SLP_SECTORS{1'b0}}; // R6 R11
      v_ldown      <= {`SLP_SECTORS{1'b0}}; // R10
      sub_wlock    <= {NSUB{1'b0}};
      sub_ldown    <= {NSUB{1'b0}};
      state        <= ST_IDLE;
      timer        <= 32'h0;
      pend_sector  <= {`SLP_SEC_W{1'b0}};
      rsp_valid    <= 1'b0;
      rsp_data     <= `SLP_VREG_RESET;
      rsp_allowed  <= 1'b0;
      cmd_rejected <= 1'b0;
    end
    else if (soft_reset)
    begin
      v_wlock      <= {`SLP_SECTORS{1'b0}}; // R6
      v_ldown      <= {`SLP_SECTORS{1'b0}};
      sub_wlock    <= {NSUB{1'b0}};
      sub_ldown    <= {NSUB{1'b0}};
      rsp_valid    <= 1'b0;
      cmd_rejected <= 1'b0;
      // A running persistent operation keeps counting
      if (state != ST_IDLE)
      begin
        if (timer == 32'h0)
          state <= ST_IDLE;
        else
          timer <= timer - 32'h1;
      end
    end
    else
    begin
      rsp_valid    <= 1'b0;
      cmd_rejected <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (take)
          begin
            case (cmd_code)
              `SLP_CMD_NV_WRITE:
              begin
                if (nv_ok)
                begin
                  state       <= ST_PROG;
                  timer       <= PROG_CYCLES - 1;
                  pend_sector <= cmd_sector;
                end
                else
                  cmd_rejected <= 1'b1; // R13
              end
              `SLP_CMD_NV_ERASE:
              begin
                if (nv_ok)
                begin
                  state <= ST_ERASE;
                  timer <= ERASE_CYCLES - 1;
                end
                else
                  cmd_rejected <= 1'b1; // R13
              end
              `SLP_CMD_NV_READ:
              begin
                rsp_valid <= 1'b1; // R8
                rsp_data  <= {7'h00, nv_lock[cmd_sector]};
              end
              `SLP_CMD_V_WRITE:
              begin
                if (vol_ok)
                begin
                  if (edge_sel)
                  begin
                    sub_wlock[si] <= cmd_wdata[`SLP_VREG_WLOCK]; // R12
                    sub_ldown[si] <= cmd_wdata[`SLP_VREG_LDOWN];
                  end
                  else
                  begin
                    v_wlock[cmd_sector] <= cmd_wdata[`SLP_VREG_WLOCK]; // R7
                    v_ldown[cmd_sector] <= cmd_wdata[`SLP_VREG_LDOWN];
                  end
                end
                else
                  cmd_rejected <= 1'b1; // R9
              end
              `SLP_CMD_V_READ:
              begin
                rsp_valid <= 1'b1; // R8
                rsp_data  <= {6'h00, cur_ld, cur_wl}; // R15
              end
              // Check: may program or erase run on this address
              `SLP_CMD_CHECK:
              begin
                rsp_valid   <= 1'b1;
                rsp_allowed <= nv_lock[cmd_sector] && !cur_wl; // R14 R2 R5
                rsp_data    <= {7'h00, nv_lock[cmd_sector] && !cur_wl};
              end
              default:
              begin
                cmd_rejected <= 1'b1;
              end
            endcase
          end
        end
        ST_PROG, ST_ERASE:
        begin
          if (timer == 32'h0)
            state <= ST_IDLE;
          else
            timer <= timer - 32'h1;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // slp_sector_lock

// [common/slp_regs.vh]
// Constants for the sector lock protection block
`ifndef SLP_REGS_VH
`define SLP_REGS_VH
`define SLP_SECTORS        1024
`define SLP_SEC_W          10
`define SLP_SUB_PER_SEC    16
`define SLP_SUB_W          4
`define SLP_VREG_W         8
`define SLP_VREG_WLOCK     0
`define SLP_VREG_LDOWN     1
`define SLP_VREG_RESET     8'h00
`define SLP_NV_UNLOCKED    1'b1
`define SLP_NV_LOCKED      1'b0
`define SLP_CMD_W          3
`define SLP_CMD_NONE       3'h0
`define SLP_CMD_NV_WRITE   3'h1
`define SLP_CMD_NV_ERASE   3'h2
`define SLP_CMD_NV_READ    3'h3
`define SLP_CMD_V_WRITE    3'h4
`define SLP_CMD_V_READ     3'h5
`define SLP_CMD_CHECK      3'h6
`define SLP_T_NV_PROG_NS   50000
`define SLP_T_NV_ERASE_NS  100000
`define SLP_CLK_NS         5
`endif

// [verif/slp_sector_lock_asserts.sv]
// Checker for the sector lock block ports
`timescale 1ns/1ps
module slp_chk #(
  parameter PROG_CYCLES  = 4,
  parameter ERASE_CYCLES = 8
) (
  input wire       clk,
  input wire       rst_n,
  input wire       cmd_valid,
  input wire [2:0] cmd_code,
  input wire       global_freeze,
  input wire       cmd_ready,
  input wire       rsp_valid,
  input wire [7:0] rsp_data,
  input wire       rsp_allowed,
  input wire       cmd_rejected,
  input wire       busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire tk = cmd_valid && cmd_ready;
  property p_rdy; busy |-> !cmd_ready ##1 !rsp_valid && !cmd_rejected; endproperty
  a_rdy: assert property (p_rdy) else $error("answer while busy");
  property p_rsp; rsp_valid |-> $past(tk) && $past(cmd_code) inside {3'h3, 3'h5, 3'h6}; endproperty
  a_rsp: assert property (p_rsp) else $error("stray answer");
  property p_prog; tk && cmd_code == 3'h1 && global_freeze |=> busy [*4] ##1 !busy; endproperty
  a_prog: assert property (p_prog) else $error("program time");
  property p_era; tk && cmd_code == 3'h2 && global_freeze |=> busy [*8] ##1 !busy; endproperty
  a_era: assert property (p_era) else $error("erase time");
  property p_frz; tk && cmd_code inside {3'h1, 3'h2} && !global_freeze |=> cmd_rejected && !busy;
  endproperty
  a_frz: assert property (p_frz) else $error("frozen bits changed");
  property p_vrd; tk && cmd_code == 3'h5 |=> rsp_valid && rsp_data[7:2] == 6'h00; endproperty
  a_vrd: assert property (p_vrd) else $error("reserved bits set");
  property p_nvrd; tk && cmd_code == 3'h3 |=> rsp_valid && rsp_data[7:1] == 7'h00; endproperty
  a_nvrd: assert property (p_nvrd) else $error("persistent read");
  property p_chk; tk && cmd_code == 3'h6 |=> rsp_valid && rsp_data == {7'h00, rsp_allowed};
  endproperty
  a_chk: assert property (p_chk) else $error("check result");
endmodule // slp_chk
bind slp_sector_lock slp_chk #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) slp_chk_inst (
  .clk           (clk),
  .rst_n         (rst_n),
  .cmd_valid     (cmd_valid),
  .cmd_code      (cmd_code),
  .global_freeze (global_freeze),
  .cmd_ready     (cmd_ready),
  .rsp_valid     (rsp_valid),
  .rsp_data      (rsp_data),
  .rsp_allowed   (rsp_allowed),
  .cmd_rejected  (cmd_rejected),
  .busy          (busy)
);

// [verif/slp_host.sv]
// Host model issuing lock commands
`timescale 1ns/1ps
module slp_host (
  input  wire       clk,
  input  wire       busy,
  input  wire       rsp_valid,
  input  wire [7:0] rsp_data,
  input  wire       cmd_rejected,
  output reg        cmd_valid,
  output reg  [2:0] cmd_code,
  output reg  [9:0] cmd_sector,
  output reg  [3:0] cmd_subsector,
  output reg  [7:0] cmd_wdata
);
  initial {cmd_valid, cmd_code, cmd_sector, cmd_subsector, cmd_wdata} = 26'h0;
  task issue(input [2:0] c, input [9:0] s, input [3:0] u, input [7:0] w,
             output [7:0] d, output r, output v, output ok);
    integer i;
    begin
      @(negedge clk);
      {cmd_valid, cmd_code, cmd_sector, cmd_subsector, cmd_wdata} = {1'b1, c, s, u, w};
      // Hold the request until an edge that finds the block idle
      for (i = 0; i < 20 && busy; i = i + 1)
        @(negedge clk);
      ok = !busy;
      @(negedge clk);
      d = rsp_data;
      r = cmd_rejected;
      v = rsp_valid;
      cmd_valid = 1'b0;
      // Released lines show the inverse
      {cmd_code, cmd_sector, cmd_subsector, cmd_wdata} = ~{c, s, u, w};
      for (i = 0; i < 20 && busy; i = i + 1)
        @(negedge clk);
      ok = ok && !busy;
    end
  endtask
endmodule // slp_host

// [verif/tb.sv]
// Self-checking bench for the sector lock block
`timescale 1ns/1ps
module tb;
  reg        clk = 0, rst_n = 0, soft_reset = 0, global_freeze = 1, r, v, ok;
  reg  [9:0] sec = 10'h5;
  reg  [3:0] sub = 4'h0;
  reg  [7:0] d;
  wire       cmd_valid, cmd_ready, rsp_valid, rsp_allowed, cmd_rejected, busy;
  wire [2:0] cmd_code;
  wire [9:0] cmd_sector;
  wire [3:0] cmd_subsector;
  wire [7:0] cmd_wdata, rsp_data;
  integer    errors = 0, n_compared = 0;
  slp_sector_lock #(.PROG_CYCLES(4), .ERASE_CYCLES(8)) slp_sector_lock_inst (
    .clk           (clk),
    .rst_n         (rst_n),
    .soft_reset    (soft_reset),
    .cmd_valid     (cmd_valid),
    .cmd_code      (cmd_code),
    .cmd_sector    (cmd_sector),
    .cmd_subsector (cmd_subsector),
    .cmd_wdata     (cmd_wdata),
    .global_freeze (global_freeze),
    .cmd_ready     (cmd_ready),
    .rsp_valid     (rsp_valid),
    .rsp_data      (rsp_data),
    .rsp_allowed   (rsp_allowed),
    .cmd_rejected  (cmd_rejected),
    .busy          (busy)
  );
  slp_host slp_host_inst (
    .clk           (clk),
    .busy          (busy),
    .rsp_valid     (rsp_valid),
    .rsp_data      (rsp_data),
    .cmd_rejected  (cmd_rejected),
    .cmd_valid     (cmd_valid),
    .cmd_code      (cmd_code),
    .cmd_sector    (cmd_sector),
    .cmd_subsector (cmd_subsector),
    .cmd_wdata     (cmd_wdata)
  );
  initial forever #2.5 clk = ~clk;
  task give_verdict;
    begin
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task cmd(input [2:0] c, input [7:0] w);
    begin
      slp_host_inst.issue(c, sec, sub, w, d, r, v, ok);
      if (!ok)
      begin
        errors = errors + 1;
        $display("wrong value at %0t: command timed out", $time);
        give_verdict;
      end
    end
  endtask
  task t_clear;
    begin
      chk({5'h0, cmd_ready, busy, rsp_valid}, 8'h04);
      cmd(3'h5, 8'h00); chk(d, 8'h00);
      chk({7'h0, v}, 8'h01);
      cmd(3'h3, 8'h00); chk(d, 8'h01);
      cmd(3'h6, 8'h00); chk(d, 8'h01);
    end
  endtask
  task t_vol;
    begin
      cmd(3'h4, 8'hfd); cmd(3'h5, 8'h00); chk(d, 8'h01);
      cmd(3'h6, 8'h00); chk({7'h0, rsp_allowed}, 8'h00);
      cmd(3'h4, 8'h03); cmd(3'h4, 8'h00); chk({7'h0, r}, 8'h01);
      cmd(3'h5, 8'h00); chk(d, 8'h03);
      soft_reset = 1;
      @(negedge clk) soft_reset = 0;
      cmd(3'h5, 8'h00); chk(d, 8'h00);
    end
  endtask
  task t_sub;
    begin
      sec = 10'h0; sub = 4'h3;
      cmd(3'h4, 8'h01); cmd(3'h5, 8'h00); chk(d, 8'h01);
      sub = 4'h4;
      cmd(3'h5, 8'h00); chk(d, 8'h00);
      sec = 10'h3ff;
      sub = 4'h3;
      cmd(3'h5, 8'h00);
      chk(d, 8'h00);
    end
  endtask
  task t_nv;
    begin
      sec = 10'h7; global_freeze = 0;
      cmd(3'h1, 8'h00); chk({7'h0, r}, 8'h01);
      cmd(3'h3, 8'h00); chk(d, 8'h01);
      global_freeze = 1;
      cmd(3'h1, 8'h00);
      chk({6'h0, v, r}, 8'h00);
      cmd(3'h3, 8'h00);
      chk(d, 8'h00);
      cmd(3'h6, 8'h00); chk(d, 8'h00);
      cmd(3'h4, 8'h01);
      rst_n = 0;
      repeat (2) @(negedge clk);
      rst_n = 1;
      chk({5'h0, cmd_ready, busy, rsp_valid}, 8'h04);
      cmd(3'h3, 8'h00); chk(d, 8'h00);
      cmd(3'h5, 8'h00);
      chk(d, 8'h00);
      cmd(3'h2, 8'h00); cmd(3'h3, 8'h00); chk(d, 8'h01);
    end
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1;
    t_clear;
    t_vol;
    t_sub;
    t_nv;
    give_verdict;
  end
endmodule // tb
